//--- design/nfh_params.svh
`ifndef NFH_PARAMS_SVH
`define NFH_PARAMS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define NFH_CLK_NS 50
`define NFH_TWB_NS 100
`define NFH_TWB_CYC ((`NFH_TWB_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
// ----------------------------------------
// array geometry
// ----------------------------------------
`define NFH_PAGE_BYTES 2112
`define NFH_PAGES_PER_BLOCK 64
`define NFH_BLOCKS 8192
`define NFH_ADDR_CYCLES 5
`define NFH_ROW_CYCLES 3
`define NFH_ID_BYTES 5
// ----------------------------------------
// command codes
// ----------------------------------------
`define NFH_C_READ1 8'h00
`define NFH_C_READ2 8'h30
`define NFH_C_COPY_READ2 8'h35
`define NFH_C_PROG1 8'h80
`define NFH_C_PROG2 8'h10
`define NFH_C_COPY_PROG1 8'h85
`define NFH_C_ERASE1 8'h60
`define NFH_C_ERASE2 8'hD0
`define NFH_C_STATUS 8'h70
`define NFH_C_EDC_STATUS 8'h7B
`define NFH_C_READ_ID 8'h90
`define NFH_C_RESET 8'hFF
`define NFH_C_NONE 8'h00
`endif

//--- design/nfh_pkg.sv
package nfh_pkg;
    typedef enum logic [3:0] {
        NFH_OP_READ, NFH_OP_PROG, NFH_OP_ERASE, NFH_OP_STATUS, NFH_OP_EDC_STATUS,
        NFH_OP_READ_ID, NFH_OP_RESET, NFH_OP_COPY_READ, NFH_OP_COPY_PROG
    } nfh_op_e;

    typedef enum logic [2:0] {
        NFH_ST_IDLE, NFH_ST_CMD1, NFH_ST_ADDR, NFH_ST_WDATA,
        NFH_ST_CMD2, NFH_ST_WAITB, NFH_ST_RDATA, NFH_ST_DONE
    } nfh_state_e;

    typedef struct packed {
        nfh_op_e op;
        logic [12:0] block;
        logic [5:0] page;
        logic [11:0] column;
        logic [11:0] len;
    } nfh_req_s;

    typedef struct packed {
        logic [7:0] cmd1;
        logic [7:0] cmd2;
        logic has_cmd2;
        logic [2:0] naddr;
        logic wdata;
        logic rdata;
        logic busy;
        logic modify;
        logic need_ready;
    } nfh_plan_s;

    typedef struct packed {
        logic [1:0] sel_n;
        logic cle;
        logic ale;
        logic we_n;
        logic re_n;
        logic unlock;
        logic [7:0] io;
        logic io_oe;
    } nfh_pins_s;

    typedef struct packed {
        nfh_state_e st;
        nfh_req_s req;
        nfh_plan_s plan;
        nfh_pins_s pins;
        logic ph;
        logic [2:0] aidx;
        logic [2:0] aleft;
        logic [11:0] cnt;
        logic [7:0] wait_cnt;
        logic [7:0] div;
        logic cmd_ready;
        logic wr_ready;
        logic done;
    } nfh_ctl_s;
endpackage

//--- design/nfh_fifo.sv
module nfh_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // fill side
    input wire logic in_valid_in,
    input wire logic [W-1:0] in_data_in,
    output logic in_ready_out,
    // drain side
    output logic out_valid_out,
    output logic [W-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("fifo depth must be a power of two, at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic ov;
        logic [W-1:0] od;
    } nfh_fifo_s;

    nfh_fifo_s q, d;
    logic wr, ld;

    assign in_ready_out = q.cnt != (AW+1)'(DEPTH);
    assign out_valid_out = q.ov;
    assign out_data_out = q.od;

    always_comb begin
        d = q;
        wr = in_valid_in && in_ready_out;
        ld = (q.cnt != '0) && (!q.ov || out_ready_in);
        if (wr) begin
            d.mem[q.wp] = in_data_in;
            d.wp = q.wp + 1'b1;
        end
        if (ld) begin
            d.od = q.mem[q.rp];
            d.rp = q.rp + 1'b1;
            d.ov = 1'b1;
        end else if (out_ready_in) begin
            d.ov = 1'b0;
        end
        d.cnt = q.cnt + (AW+1)'(wr) - (AW+1)'(ld);
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

//--- design/nfh_ctrl.sv
// Summary of operation
// - with command latch high, the write strobe rise captures a command byte
// - with address latch high, the write strobe rise captures an address byte
// - all inbound bytes are sampled only at the write strobe rising edge
// - one eight-bit bus carries commands, addresses, write and read data
// - ready/busy lines may be wired together; low means some device busy
// - 8192 blocks of 64 pages, 2112 bytes per page; program whole pages (the controller programs len bytes from column, at most one page)
// - data may be read out after a single or multi-plane copy-back read (the controller issues single-plane copy-back reads only)
// - a full address is five consecutive address latch cycles
// - write lock held high through program or erase command cycles
// - to read, select low, write strobe high, latches low, toggle read strobe
`include "nfh_params.svh"

module nfh_ctrl #(
    parameter int STROBE_DIV = 1,
    parameter int FIFO_DEPTH = 32
) (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RST_IN,
    // command port
    input wire logic CMD_VALID_IN,
    input wire nfh_pkg::nfh_req_s CMD_IN,
    output logic CMD_READY_OUT,
    output logic DONE_OUT,
    // program data stream
    input wire logic WR_VALID_IN,
    input wire logic [7:0] WR_DATA_IN,
    output logic WR_READY_OUT,
    // read data stream
    output logic RD_VALID_OUT,
    output logic [7:0] RD_DATA_OUT,
    input wire logic RD_READY_IN,
    // flash pins
    output logic [1:0] DEVICE_SELECT_N_OUT,
    output logic CMD_LATCH_OUT,
    output logic ADDR_LATCH_OUT,
    output logic WRITE_STROBE_N_OUT,
    output logic READ_STROBE_N_OUT,
    output logic WRITE_UNLOCK_OUT,
    input wire logic READY_BUSY_N_IN,
    input wire logic [7:0] IO_BUS_IN,
    output logic [7:0] IO_BUS_OUT,
    output logic IO_BUS_OE_OUT
);
    localparam logic [7:0] TWB_CYC = 8'(`NFH_TWB_CYC);
    localparam logic [7:0] DIV_LAST = 8'(STROBE_DIV - 1);
    localparam logic [11:0] PAGE = 12'(`NFH_PAGE_BYTES);

    if (STROBE_DIV < 1 || STROBE_DIV > 256) begin : g_chk_div
        $error("strobe divider out of range");
    end
    if (FIFO_DEPTH < 2) begin : g_chk_fifo
        $error("fifo depth too small");
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic nfh_pkg::nfh_plan_s plan_of(input nfh_pkg::nfh_op_e op);
        unique case (op)
            nfh_pkg::NFH_OP_READ: plan_of = '{`NFH_C_READ1, `NFH_C_READ2, 1'b1, 3'd5, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
            nfh_pkg::NFH_OP_PROG: plan_of = '{`NFH_C_PROG1, `NFH_C_PROG2, 1'b1, 3'd5, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
            nfh_pkg::NFH_OP_ERASE: plan_of = '{`NFH_C_ERASE1, `NFH_C_ERASE2, 1'b1, 3'd3, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
            nfh_pkg::NFH_OP_STATUS: plan_of = '{`NFH_C_STATUS, `NFH_C_NONE, 1'b0, 3'd0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
            nfh_pkg::NFH_OP_EDC_STATUS:
                plan_of = '{`NFH_C_EDC_STATUS, `NFH_C_NONE, 1'b0, 3'd0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
            nfh_pkg::NFH_OP_READ_ID: plan_of = '{`NFH_C_READ_ID, `NFH_C_NONE, 1'b0, 3'd1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
            nfh_pkg::NFH_OP_RESET: plan_of = '{`NFH_C_RESET, `NFH_C_NONE, 1'b0, 3'd0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
            nfh_pkg::NFH_OP_COPY_READ:
                plan_of = '{`NFH_C_READ1, `NFH_C_COPY_READ2, 1'b1, 3'd5, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
            nfh_pkg::NFH_OP_COPY_PROG:
                plan_of = '{`NFH_C_COPY_PROG1, `NFH_C_PROG2, 1'b1, 3'd5, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
            default: plan_of = '0;
        endcase
    endfunction

    // next phase after stage k: 0 cmd1, 1 address, 2 write data, 3 cmd2, 4 busy wait
    function automatic nfh_pkg::nfh_state_e next_st(input int k, input nfh_pkg::nfh_plan_s p,
                                                    input logic [11:0] n);
        if (k < 1 && p.naddr != 3'd0) return nfh_pkg::NFH_ST_ADDR;
        if (k < 2 && p.wdata && n != '0) return nfh_pkg::NFH_ST_WDATA;
        if (k < 3 && p.has_cmd2) return nfh_pkg::NFH_ST_CMD2;
        if (k < 4 && p.busy) return nfh_pkg::NFH_ST_WAITB;
        if (p.rdata && n != '0) return nfh_pkg::NFH_ST_RDATA;
        return nfh_pkg::NFH_ST_DONE;
    endfunction

    function automatic logic [1:0] sel_of(input logic [12:0] block);
        return block[12] ? 2'b01 : 2'b10;
    endfunction

    function automatic logic [7:0] addr_byte(input nfh_pkg::nfh_req_s r, input logic [2:0] i);
        logic [17:0] row;
        row = {r.block[11:0], r.page};
        if (r.op == nfh_pkg::NFH_OP_READ_ID) return 8'h00;
        unique case (i)
            3'd0: return r.column[7:0];
            3'd1: return {4'h0, r.column[11:8]};
            3'd2: return row[7:0];
            3'd3: return row[15:8];
            3'd4: return {6'h00, row[17:16]};
            default: return 8'h00;
        endcase
    endfunction

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    nfh_pkg::nfh_ctl_s q, d;
    logic tick, push, accept, fifo_in_ready;

    assign tick = q.div == DIV_LAST;

    always_comb begin
        nfh_pkg::nfh_plan_s p;
        logic go;
        p = plan_of(CMD_IN.op);
        go = 1'b0;
        d = q;
        d.done = 1'b0;
        d.wr_ready = 1'b0;
        d.div = tick ? 8'h00 : q.div + 8'h01;
        push = 1'b0;
        accept = 1'b0;
        unique case (q.st)
            nfh_pkg::NFH_ST_IDLE: begin
                accept = q.cmd_ready && CMD_VALID_IN && (READY_BUSY_N_IN || !p.need_ready);
                d.cmd_ready = !accept;
                if (accept) begin
                    d.req = CMD_IN;
                    if (CMD_IN.len > PAGE) begin
                        d.req.len = PAGE;
                    end
                    d.plan = p;
                    d.pins.unlock = p.modify;
                    d.ph = 1'b0;
                    d.st = nfh_pkg::NFH_ST_CMD1;
                end
            end
            nfh_pkg::NFH_ST_CMD1, nfh_pkg::NFH_ST_ADDR, nfh_pkg::NFH_ST_WDATA, nfh_pkg::NFH_ST_CMD2: begin
                go = (q.st == nfh_pkg::NFH_ST_WDATA) ? (q.wr_ready && WR_VALID_IN) : tick;
                if (!q.ph && go) begin
                    d.pins.sel_n = sel_of(q.req.block);
                    d.pins.cle = q.st == nfh_pkg::NFH_ST_CMD1 || q.st == nfh_pkg::NFH_ST_CMD2;
                    d.pins.ale = q.st == nfh_pkg::NFH_ST_ADDR;
                    d.pins.io = (q.st == nfh_pkg::NFH_ST_CMD1) ? q.plan.cmd1 :
                                (q.st == nfh_pkg::NFH_ST_CMD2) ? q.plan.cmd2 :
                                (q.st == nfh_pkg::NFH_ST_ADDR) ? addr_byte(q.req, q.aidx) : WR_DATA_IN;
                    d.pins.io_oe = 1'b1;
                    d.pins.we_n = 1'b0;
                    d.ph = 1'b1;
                    d.div = 8'h00;
                end else if (q.ph && tick) begin
                    d.pins.we_n = 1'b1;
                    d.ph = 1'b0;
                    unique case (q.st)
                        nfh_pkg::NFH_ST_CMD1: begin
                            d.aidx = (q.plan.naddr == 3'd`NFH_ROW_CYCLES) ? 3'd2 : 3'd0;
                            d.aleft = q.plan.naddr;
                            d.st = next_st(0, q.plan, q.req.len);
                        end
                        nfh_pkg::NFH_ST_ADDR: begin
                            d.aidx = q.aidx + 3'd1;
                            d.aleft = q.aleft - 3'd1;
                            if (q.aleft == 3'd1) begin
                                d.st = next_st(1, q.plan, q.req.len);
                            end
                        end
                        nfh_pkg::NFH_ST_WDATA: begin
                            d.cnt = q.cnt + 12'd1;
                            if (q.cnt + 12'd1 == q.req.len) begin
                                d.st = next_st(2, q.plan, q.req.len);
                            end
                        end
                        nfh_pkg::NFH_ST_CMD2: begin
                            d.st = next_st(3, q.plan, q.req.len);
                        end
                    endcase
                end
                d.wr_ready = d.st == nfh_pkg::NFH_ST_WDATA && !d.ph;
            end
            nfh_pkg::NFH_ST_WAITB: begin
                d.pins.sel_n = 2'b11;
                d.pins.cle = 1'b0;
                d.pins.ale = 1'b0;
                d.pins.io_oe = 1'b0;
                if (q.wait_cnt != TWB_CYC) begin
                    d.wait_cnt = q.wait_cnt + 8'h01;
                end else if (READY_BUSY_N_IN) begin
                    d.st = next_st(4, q.plan, q.req.len);
                end
            end
            nfh_pkg::NFH_ST_RDATA: begin
                d.pins.sel_n = sel_of(q.req.block);
                d.pins.cle = 1'b0;
                d.pins.ale = 1'b0;
                d.pins.io_oe = 1'b0;
                if (tick && !q.ph && fifo_in_ready && q.pins.sel_n == sel_of(q.req.block)) begin
                    d.pins.re_n = 1'b0;
                    d.ph = 1'b1;
                end else if (tick && q.ph) begin
                    push = 1'b1;
                    d.pins.re_n = 1'b1;
                    d.ph = 1'b0;
                    d.cnt = q.cnt + 12'd1;
                    if (q.cnt + 12'd1 == q.req.len) begin
                        d.st = nfh_pkg::NFH_ST_DONE;
                    end
                end
            end
            nfh_pkg::NFH_ST_DONE: begin
                d.pins.sel_n = 2'b11;
                d.pins.cle = 1'b0;
                d.pins.ale = 1'b0;
                d.pins.io_oe = 1'b0;
                d.pins.unlock = 1'b0;
                d.done = 1'b1;
                d.st = nfh_pkg::NFH_ST_IDLE;
            end
        endcase
        if (d.st != q.st) begin
            d.cnt = '0;
            d.wait_cnt = '0;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            q <= '0;
            q.pins.sel_n <= 2'b11;
            q.pins.we_n <= 1'b1;
            q.pins.re_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------
    // read buffer and outputs
    // ----------------------------------------
    nfh_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in(CLK_IN),
        .rst_in(RST_IN),
        .in_valid_in(push),
        .in_data_in(IO_BUS_IN),
        .in_ready_out(fifo_in_ready),
        .out_valid_out(RD_VALID_OUT),
        .out_data_out(RD_DATA_OUT),
        .out_ready_in(RD_READY_IN)
    );

    assign CMD_READY_OUT = q.cmd_ready;
    assign DONE_OUT = q.done;
    assign WR_READY_OUT = q.wr_ready;
    assign DEVICE_SELECT_N_OUT = q.pins.sel_n;
    assign CMD_LATCH_OUT = q.pins.cle;
    assign ADDR_LATCH_OUT = q.pins.ale;
    assign WRITE_STROBE_N_OUT = q.pins.we_n;
    assign READ_STROBE_N_OUT = q.pins.re_n;
    assign WRITE_UNLOCK_OUT = q.pins.unlock;
    assign IO_BUS_OUT = q.pins.io;
    assign IO_BUS_OE_OUT = q.pins.io_oe;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [2:0] nadr_q;
    always_ff @(posedge CLK_IN) begin
        if (RST_IN || ($rose(q.pins.we_n) && q.pins.cle)) begin
            nadr_q <= 3'd0;
        end else if ($rose(q.pins.we_n) && q.pins.ale) begin
            nadr_q <= nadr_q + 3'd1;
        end
    end

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    cmd_latch_a: assert property ($rose(q.pins.we_n) && q.pins.cle |-> q.pins.io_oe && !q.pins.ale && $past(q.pins.cle))
        else $error("command byte latched without clean command cycle");
    addr_latch_a: assert property ($rose(q.pins.we_n) && q.pins.ale |-> q.pins.io_oe && !q.pins.cle && $past(q.pins.ale))
        else $error("address byte latched without clean address cycle");
    strobe_hold_a: assert property (!q.pins.we_n |=> $stable(q.pins.io) && $stable(q.pins.cle) && $stable(q.pins.ale))
        else $error("bus changed while write strobe low");
    bus_share_a: assert property (!q.pins.re_n |-> !q.pins.io_oe && q.pins.we_n)
        else $error("host drives bus during read strobe");
    five_addr_a: assert property ($rose(q.pins.we_n) && q.pins.cle && q.pins.io inside {`NFH_C_READ2, `NFH_C_COPY_READ2}
        |-> nadr_q == 3'd`NFH_ADDR_CYCLES)
        else $error("page read confirmed without five address cycles");
    lock_hold_a: assert property (!q.pins.we_n && q.plan.modify |-> q.pins.unlock ##1 q.pins.unlock)
        else $error("write unlock low during modify command cycle");
    read_pins_a: assert property (!q.pins.re_n |-> $onehot(~q.pins.sel_n) && !q.pins.cle && !q.pins.ale)
        else $error("read strobe with wrong pin state");
    ready_wait_a: assert property ($past(q.st) == nfh_pkg::NFH_ST_IDLE && q.st == nfh_pkg::NFH_ST_CMD1
        && q.plan.need_ready |-> $past(READY_BUSY_N_IN))
        else $error("array command started while busy");
    busy_leave_a: assert property ($past(q.st) == nfh_pkg::NFH_ST_WAITB && q.st != nfh_pkg::NFH_ST_WAITB
        |-> $past(READY_BUSY_N_IN) && $past(q.wait_cnt) == TWB_CYC)
        else $error("busy wait left while line busy");
    page_len_a: assert property (q.st != nfh_pkg::NFH_ST_IDLE |-> q.req.len <= PAGE && q.cnt <= PAGE)
        else $error("transfer exceeds one page");

    read_done_c: cover property (q.done && q.req.op == nfh_pkg::NFH_OP_READ && q.req.len != '0);
    prog_done_c: cover property (q.done && q.req.op == nfh_pkg::NFH_OP_PROG && q.req.len != '0);
    erase_done_c: cover property (q.done && q.req.op == nfh_pkg::NFH_OP_ERASE);
    copy_read_c: cover property (q.done && q.req.op == nfh_pkg::NFH_OP_COPY_READ && q.req.len != '0);
endmodule

//--- tb/nfh_flash_model.sv
module nfh_flash_model #(
    parameter int BUSY_CYC = 20,
    parameter logic [7:0] ID_BASE = 8'h5a, // arbitrary value
    parameter logic [7:0] EDC_VAL = 8'h00
) (
    // clock
    input wire logic clk_in,
    // host strobes
    input wire logic [1:0] sel_n_in,
    input wire logic cle_in,
    input wire logic ale_in,
    input wire logic we_n_in,
    input wire logic re_n_in,
    input wire logic wp_in,
    // bus and status
    input wire logic [7:0] io_in,
    output logic rb_n_out,
    output logic [7:0] io_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [7:0] mem [0:2111];
    logic [7:0] cmd_q, last_q, busy_q, cur;
    logic [11:0] ptr_q;
    logic [2:0] ac_q, idx_q;
    logic we_q, re_q, fail_q, sel;
    initial begin
        for (int i = 0; i < 2112; i++) mem[i] = i[7:0] ^ 8'h3c;
        {cmd_q, last_q, busy_q, ptr_q, ac_q, idx_q, fail_q} = '0;
        we_q = 1'b1;
        re_q = 1'b1;
    end
    assign sel = sel_n_in != 2'b11;
    assign rb_n_out = busy_q == 8'h00;
    always_comb begin
        case (cmd_q)
            8'h70: cur = {1'b0, rb_n_out, 5'h00, fail_q};
            8'h7b: cur = EDC_VAL;
            8'h90: cur = ID_BASE + 8'(idx_q);
            default: cur = mem[ptr_q];
        endcase
    end
    // released bus shows inverse of last level
    assign io_out = (sel && !re_n_in) ? cur : ~last_q;
    // ----------------------------------------
    // capture and read-out
    // ----------------------------------------
    always @(posedge clk_in) begin
        we_q <= we_n_in;
        re_q <= re_n_in;
        last_q <= io_in;
        if (busy_q != 8'h00) busy_q <= busy_q - 8'h01;
        if (sel && !we_q && we_n_in) begin
            if (cle_in) begin
                cmd_q <= io_in;
                idx_q <= 3'h0;
                if (io_in == 8'h00 || io_in == 8'h80 || io_in == 8'h85 || io_in == 8'h60) ac_q <= 3'h0;
                if (io_in == 8'h30 || io_in == 8'h35 || io_in == 8'hff) busy_q <= 8'(BUSY_CYC);
                if (io_in == 8'hff) fail_q <= 1'b0;
                if (io_in == 8'h10 || io_in == 8'hd0) begin
                    if (wp_in) busy_q <= 8'(BUSY_CYC);
                    else fail_q <= 1'b1;
                end
            end else if (ale_in) begin
                ac_q <= ac_q + 3'h1;
                if (ac_q == 3'h0) ptr_q[7:0] <= io_in;
                if (ac_q == 3'h1) ptr_q[11:8] <= io_in[3:0];
            end else if (cmd_q == 8'h80) begin
                mem[ptr_q] <= io_in;
                ptr_q <= ptr_q + 12'h001;
            end
        end
        if (sel && re_q && !re_n_in) begin
            ptr_q <= ptr_q + 12'h001;
            idx_q <= idx_q + 3'h1;
        end
    end
endmodule

//--- tb/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic CLK_IN, RST_IN, CMD_VALID_IN, CMD_READY_OUT, DONE_OUT, WR_VALID_IN, WR_READY_OUT;
    logic RD_VALID_OUT, RD_READY_IN, CMD_LATCH_OUT, ADDR_LATCH_OUT, WRITE_STROBE_N_OUT;
    logic READ_STROBE_N_OUT, WRITE_UNLOCK_OUT, ready_busy_n, IO_BUS_OE_OUT, stall;
    logic [7:0] WR_DATA_IN, RD_DATA_OUT, IO_BUS_OUT, dev_io, io_bus;
    logic [1:0] DEVICE_SELECT_N_OUT;
    nfh_pkg::nfh_req_s CMD_IN;
    logic [7:0] exp_q[$], wq[$], pd[8];
    logic [31:0] rnd, seed;
    int n_fail, checks_done, cyc;
    // ----------------------------------------
    // instances
    // ----------------------------------------
    assign io_bus = IO_BUS_OE_OUT ? IO_BUS_OUT : dev_io;
    nfh_ctrl i_nfh_ctrl (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .CMD_VALID_IN(CMD_VALID_IN), .CMD_IN(CMD_IN),
        .CMD_READY_OUT(CMD_READY_OUT), .DONE_OUT(DONE_OUT), .WR_VALID_IN(WR_VALID_IN), .WR_DATA_IN(WR_DATA_IN),
        .WR_READY_OUT(WR_READY_OUT), .RD_VALID_OUT(RD_VALID_OUT), .RD_DATA_OUT(RD_DATA_OUT),
        .RD_READY_IN(RD_READY_IN), .DEVICE_SELECT_N_OUT(DEVICE_SELECT_N_OUT), .CMD_LATCH_OUT(CMD_LATCH_OUT),
        .ADDR_LATCH_OUT(ADDR_LATCH_OUT), .WRITE_STROBE_N_OUT(WRITE_STROBE_N_OUT),
        .READ_STROBE_N_OUT(READ_STROBE_N_OUT), .WRITE_UNLOCK_OUT(WRITE_UNLOCK_OUT),
        .READY_BUSY_N_IN(ready_busy_n), .IO_BUS_IN(io_bus), .IO_BUS_OUT(IO_BUS_OUT), .IO_BUS_OE_OUT(IO_BUS_OE_OUT));
    // single device: wired-and line equals its output
    nfh_flash_model i_nfh_flash_model (.clk_in(CLK_IN), .sel_n_in(DEVICE_SELECT_N_OUT), .cle_in(CMD_LATCH_OUT),
        .ale_in(ADDR_LATCH_OUT), .we_n_in(WRITE_STROBE_N_OUT), .re_n_in(READ_STROBE_N_OUT),
        .wp_in(WRITE_UNLOCK_OUT), .io_in(io_bus), .rb_n_out(ready_busy_n), .io_out(dev_io));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic check(input string nm, input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic summarize();
        if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmd(input nfh_pkg::nfh_op_e k, input logic [12:0] b, input logic [11:0] c, input logic [11:0] n);
        int t;
        t = 0;
        while (CMD_READY_OUT !== 1'b1 && t < 500) begin
            @(posedge CLK_IN);
            #2;
            t++;
        end
        CMD_IN = '{op: k, block: b, page: 6'h05, column: c, len: n};
        CMD_VALID_IN = 1'b1;
        // hold the request until ready drops, i.e. it was taken
        t = 0;
        do begin
            @(posedge CLK_IN);
            #2;
            t++;
        end while (CMD_READY_OUT === 1'b1 && t < 500);
        CMD_VALID_IN = 1'b0;
        t = 0;
        while (DONE_OUT !== 1'b1 && t < 5000) begin
            @(posedge CLK_IN);
            #2;
            t++;
        end
        check("done", {7'h00, DONE_OUT}, 8'h01);
    endtask
    // ----------------------------------------
    // clock, drivers, monitor
    // ----------------------------------------
    initial CLK_IN = 1'b0;
    always #25 CLK_IN = ~CLK_IN;
    always @(posedge CLK_IN) begin
        #2;
        rnd = lfsr(rnd);
        RD_READY_IN = !stall || rnd[3:0] == 4'h0;
        WR_VALID_IN = wq.size() > 0;
        WR_DATA_IN = wq.size() > 0 ? wq[0] : rnd[7:0];
    end
    always @(negedge CLK_IN) begin
        if (WR_VALID_IN && WR_READY_OUT === 1'b1) void'(wq.pop_front());
        if (RD_VALID_OUT === 1'b1 && RD_READY_IN === 1'b1) begin
            if (exp_q.size() > 0) check("rd_data", RD_DATA_OUT, exp_q.pop_front());
            else check("rd_extra", 8'h01, 8'h00);
        end
    end
    always @(posedge CLK_IN) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            summarize();
        end
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        {n_fail, checks_done, cyc} = '0;
        {CMD_VALID_IN, WR_VALID_IN, WR_DATA_IN, stall} = '0;
        CMD_IN = '0;
        RD_READY_IN = 1'b1;
        RST_IN = 1'b1;
        rnd = 32'h2f43_a5ca;
        seed = 32'h2f43_a5ca;
        repeat (12) @(posedge CLK_IN);
        #2;
        RST_IN = 1'b0;
        exp_q.push_back(8'h40);
        cmd(nfh_pkg::NFH_OP_STATUS, 13'h0000, 12'h000, 12'h001);
        exp_q.push_back(8'h00);
        cmd(nfh_pkg::NFH_OP_EDC_STATUS, 13'h0000, 12'h000, 12'h001);
        for (int i = 0; i < 5; i++) exp_q.push_back(8'h5a + 8'(i));
        cmd(nfh_pkg::NFH_OP_READ_ID, 13'h0000, 12'h000, 12'h005);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            pd[i] = seed[7:0];
            wq.push_back(pd[i]);
        end
        cmd(nfh_pkg::NFH_OP_PROG, 13'h0001, 12'h010, 12'h008);
        exp_q.push_back(8'h40);
        cmd(nfh_pkg::NFH_OP_STATUS, 13'h0000, 12'h000, 12'h001);
        for (int i = 0; i < 8; i++) exp_q.push_back(pd[i]);
        cmd(nfh_pkg::NFH_OP_READ, 13'h1001, 12'h010, 12'h008);
        stall = 1'b1;
        for (int i = 24; i < 64; i++) exp_q.push_back(8'(i) ^ 8'h3c);
        cmd(nfh_pkg::NFH_OP_COPY_READ, 13'h0002, 12'h018, 12'h028);
        stall = 1'b0;
        cmd(nfh_pkg::NFH_OP_COPY_PROG, 13'h0003, 12'h000, 12'h000);
        cmd(nfh_pkg::NFH_OP_ERASE, 13'h0004, 12'h000, 12'h000);
        cmd(nfh_pkg::NFH_OP_RESET, 13'h0000, 12'h000, 12'h000);
        exp_q.push_back(8'h40);
        cmd(nfh_pkg::NFH_OP_STATUS, 13'h0000, 12'h000, 12'h001);
        repeat (40) @(posedge CLK_IN);
        check("left", 8'(exp_q.size()), 8'h00);
        summarize();
    end
endmodule
